// File: core/grim_edge.sv
// one pin's false-to-true detector, gated by its mask bit
`default_nettype none
`include "grim_map.svh"

module grim_edge (
   input  wire logic sys_clk,
   input  wire logic rst_b,
   input  wire logic pin,
   input  wire logic en,
   output var  logic evt
);
   import grim_pkg::*;

   grim_edge_t st_reg;
   grim_edge_t st_next;

   always_comb begin
      st_next        = st_reg;
      st_next.prev   = pin;
      // first sample after reset only primes; a pin already high is no edge
      st_next.primed = 1'b1;
      st_next.evt    = st_reg.primed & en & pin & ~st_reg.prev;
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign evt = st_reg.evt;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   a_rise_fires: assert property (st_reg.primed && en && pin && !st_reg.prev |=> evt)
      else $error("masked-in rising edge gave no event");
   a_rise_quiet: assert property (!en || !pin || st_reg.prev |=> !evt)
      else $error("event without an enabled rising edge");
   a_evt_single: assert property (evt |=> !evt)
      else $error("event lasted more than one cycle");

endmodule

`default_nettype wire

// File: core/grim_top.sv
// rising-edge interrupt mask with set and clear addresses, and its edge detectors
`default_nettype none
`include "grim_map.svh"

module grim_top (
   input  wire logic                     sys_clk,
   input  wire logic                     rst_b,
   input  wire grim_pkg::grim_req_t      req,
   input  wire logic [`GRIM_PIN_CNT-1:0] gpio_in,
   output var  grim_pkg::grim_rsp_t      rsp,
   output var  logic [`GRIM_DATA_W-1:0]  mask_out,
   output var  logic [`GRIM_PIN_CNT-1:0] rise_evt,
   output var  logic                     rise_irq
);
   import grim_pkg::*;

   grim_state_t              st_reg;
   grim_state_t              st_next;
   logic [`GRIM_PIN_CNT-1:0] det_evt;
   logic                     hit_set;
   logic                     hit_clr;

   ////////////////////////////////////////////////////////////////////////////
   // address decode

   assign hit_set = (req.addr == `GRIM_SET_ADDR);
   assign hit_clr = (req.addr == `GRIM_CLR_ADDR);

   ////////////////////////////////////////////////////////////////////////////
   // edge detectors, one per mapped pin

   genvar g;
   generate
      for (g = `GRIM_PIN_LSB; g <= `GRIM_PIN_MSB; g++) begin : g_pin
         grim_edge u_edge (
            .sys_clk (sys_clk),
            .rst_b   (rst_b),
            .pin     (gpio_in[g]),
            .en      (st_reg.mask[g]),
            .evt     (det_evt[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      st_next = st_reg;
      // ones act, zeros leave bits alone
      if (req.wr && hit_set) begin
         st_next.mask = st_reg.mask | req.wdata;
      end else if (req.wr && hit_clr) begin
         st_next.mask = st_reg.mask & ~req.wdata;
      end
      // spare bits 3-7 are stored and read back but steer nothing
      st_next.rsp.rvalid = req.rd;
      if (req.rd && (hit_set || hit_clr)) begin
         st_next.rsp.rdata = st_reg.mask;
      end else if (req.rd) begin
         st_next.rsp.rdata = `GRIM_UNMAPPED_RD;
      end
      // a read shows the mask as it stood before a write in the same cycle
      st_next.irq_evt = det_evt;
      st_next.irq_any = |det_evt;
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg      <= '0;
         st_reg.mask <= `GRIM_MASK_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs, all from flip-flops

   assign rsp      = st_reg.rsp;
   assign mask_out = st_reg.mask;
   assign rise_evt = st_reg.irq_evt;
   assign rise_irq = st_reg.irq_any;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   a_set_ones: assert property (req.wr && hit_set
         |=> mask_out == ($past(mask_out) | $past(req.wdata)))
      else $error("set address did not or-in written ones");

   a_clr_ones: assert property (req.wr && hit_clr
         |=> mask_out == ($past(mask_out) & ~$past(req.wdata)))
      else $error("clear address did not remove written ones");

   // an edge caught in the very cycle of the clear still comes out; the one after may not
   a_clr_stops: assert property (req.wr && hit_clr && req.wdata[1]
         |=> !mask_out[1] ##2 !rise_evt[1])
      else $error("cleared pin 1 still raised an event");

   a_set_enables: assert property (req.wr && hit_set && req.wdata[1] && !req.rd
         |=> mask_out[1])
      else $error("set address did not enable pin 1");

   a_read_same: assert property (req.rd && (hit_set || hit_clr)
         |=> rsp.rvalid && rsp.rdata == $past(mask_out))
      else $error("read at set or clear address not the mask");

   a_read_unmapped: assert property (req.rd && !hit_set && !hit_clr
         |=> rsp.rvalid && rsp.rdata == `GRIM_UNMAPPED_RD)
      else $error("unmapped read did not return zero");

   a_zero_write: assert property (req.wr && req.wdata == 8'h00 |=> $stable(mask_out))
      else $error("zero write changed the mask");

   a_other_addr: assert property (req.wr && !hit_set && !hit_clr |=> $stable(mask_out))
      else $error("write elsewhere changed the mask");

   a_full_width: assert property (req.wr && hit_set && req.wdata == 8'hff
         |=> mask_out == 8'hff)
      else $error("not every mask bit is settable");

   a_irq_cause: assert property (rise_evt[2] |-> $past(mask_out[2], 2))
      else $error("pin 2 event while its mask bit was zero");

   a_irq_any: assert property (rise_irq == (rise_evt != 3'h0))
      else $error("interrupt and pin events disagree");

endmodule

`default_nettype wire

// File: pkg/grim_map.svh
// register offsets, field layout and reset values of the rising-edge mask
//
// How it works
// - mask bit one lets rising input interrupt
// - set at 1Eh, clear at 1Fh
// - clear-address one returns mask bit to zero
// - set-address ones force matching bits high
// - clear-address ones force matching bits low
// - either address reads the same register
// - pins 0-2 at bits 0-2; 3-7 spare
`ifndef GRIM_MAP_SVH
`define GRIM_MAP_SVH

`define GRIM_ADDR_W      8
`define GRIM_DATA_W      8
`define GRIM_PIN_CNT     3
`define GRIM_SET_ADDR    8'h1e
`define GRIM_CLR_ADDR    8'h1f
`define GRIM_MASK_RST    8'h00
`define GRIM_UNMAPPED_RD 8'h00
`define GRIM_PIN_LSB     0
`define GRIM_PIN_MSB     2

`endif

// File: pkg/grim_pkg.sv
// types shared by the rising-edge mask block
`default_nettype none
`include "grim_map.svh"

package grim_pkg;

   // one register access from the serial controller port
   typedef struct packed {
      logic [`GRIM_ADDR_W-1:0] addr;
      logic [`GRIM_DATA_W-1:0] wdata;
      logic                    wr;
      logic                    rd;
   } grim_req_t;

   // read answer, one cycle after the read strobe
   typedef struct packed {
      logic [`GRIM_DATA_W-1:0] rdata;
      logic                    rvalid;
   } grim_rsp_t;

   // state of one pin's edge detector
   typedef struct packed {
      logic prev;
      logic primed;
      logic evt;
   } grim_edge_t;

   // state of the top block
   typedef struct packed {
      logic [`GRIM_DATA_W-1:0]  mask;
      grim_rsp_t                rsp;
      logic [`GRIM_PIN_CNT-1:0] irq_evt;
      logic                     irq_any;
   } grim_state_t;

endpackage

`default_nettype wire

// File: tb/grim_host.sv
// host model issuing register writes and reads on the controller port
`default_nettype none
`include "grim_map.svh"

module grim_host (
   input  wire logic                sys_clk,
   output var  grim_pkg::grim_req_t req,
   input  wire grim_pkg::grim_rsp_t rsp
);
   timeunit 1ns;
   timeprecision 1ps;
   import grim_pkg::*;

   initial req = '0;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      req <= {a, d, 2'b10};
      @(posedge sys_clk);
      // released lines show the inverse, not a stale copy
      req <= {~a, ~d, 2'b00};
   endtask

   task automatic rd(input logic [7:0] a, output logic [8:0] r);
      @(posedge sys_clk);
      req <= {a, 8'h00, 2'b01};
      @(posedge sys_clk);
      req <= {~a, 8'hff, 2'b00};
      #1;
      r = rsp;
   endtask
endmodule

`default_nettype wire

// File: tb/grim_top_tb.sv
// self-checking bench for the rising-edge mask block
`default_nettype none
`include "grim_map.svh"

module grim_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import grim_pkg::*;

   logic        sys_clk;
   logic        rst_b;
   grim_req_t   req;
   grim_rsp_t   rsp;
   logic [2:0]  gpio_in;
   logic [2:0]  rise_evt;
   logic [7:0]  mask_out;
   logic        rise_irq;
   logic [8:0]  r;
   int          err_count = 0;
   int          tests_run = 0;

   grim_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .req(req), .gpio_in(gpio_in),
                 .rsp(rsp), .mask_out(mask_out), .rise_evt(rise_evt), .rise_irq(rise_irq));
   grim_host host (.sys_clk(sys_clk), .req(req), .rsp(rsp));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [8:0] got, input logic [8:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s exp %h got %h", n, exp, got);
      end
   endtask

   task automatic test_done;
      if (err_count == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      host.rd(a, r);
      chk("rdata", r, {exp, 1'b1});
      // valid drops after one cycle, data stands until the next read
      @(posedge sys_clk);
      #1 chk("rd_hold", rsp, {exp, 1'b0});
   endtask

   // event stands for the cycle after the second edge that sees the pin high
   task automatic pulse(input int i, input logic hit);
      @(posedge sys_clk) gpio_in <= 3'(1 << i);
      repeat (2) @(posedge sys_clk);
      #1 chk("rise_evt", {5'h0, rise_irq, rise_evt}, hit ? {6'h01, 3'(1 << i)} : 9'h0);
      @(posedge sys_clk) gpio_in <= 3'h0;
      #1 chk("rise_end", {5'h0, rise_irq, rise_evt}, 9'h0);
      repeat (2) @(posedge sys_clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   initial begin
      #100us;
      err_count++;
      test_done();
   end

   initial begin
      rst_b   = 1'b0;
      gpio_in = 3'h0;
      repeat (12) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      rdchk(8'h1e, 8'h00);
      host.wr(8'h1e, 8'h28);
      #1 chk("mask_out", {1'b0, mask_out}, 9'h028);
      host.wr(8'h1e, 8'h08);
      rdchk(8'h1e, 8'h28);
      host.wr(8'h1f, 8'h88);
      rdchk(8'h1f, 8'h20);
      host.wr(8'h1f, 8'h00);
      rdchk(8'h1e, 8'h20);
      host.wr(8'h1d, 8'hff);
      rdchk(8'h1d, 8'h00);
      chk("mask_out", {1'b0, mask_out}, 9'h020);
      host.wr(8'h1e, 8'h07);
      host.wr(8'h1e, 8'hff);
      rdchk(8'h1f, 8'hff);
      host.wr(8'h1f, 8'hf8);
      rdchk(8'h1e, 8'h07);
      for (int i = 0; i < 3; i++) begin
         pulse(i, 1'b1);
      end
      host.wr(8'h1f, 8'h02);
      pulse(1, 1'b0);
      pulse(0, 1'b1);
      test_done();
   end
endmodule

`default_nettype wire
